// ### bench/pec_host_model.sv
// Host-side link model that raises the unit's event inputs
`timescale 1ns/1ps
module pec_host_model
    import pec_pkg::*;
(
    input wire logic hclk,
    output pec_events_s ev
);
    initial ev = '0;
    // One-cycle pulse; the link level is carried through unchanged
    task automatic pulse(input pec_events_s p);
        @(posedge hclk);
        p.link_ready = ev.link_ready;
        ev <= p;
        @(posedge hclk);
        ev <= '{link_ready: p.link_ready, default: 1'b0};
    endtask
    task automatic link(input logic up);
        @(posedge hclk);
        ev.link_ready <= up;
    endtask
    // Signature frame, then the host answer after a chosen gap
    task automatic sig(input logic ok, input int dly);
        pec_events_s p;
        p = '0;
        p.sig_sent = 1'b1;
        pulse(p);
        repeat (dly) @(posedge hclk);
        p = '0;
        p.sig_rok = ok;
        p.sig_rerr = !ok;
        pulse(p);
    endtask
endmodule

// ### bench/pec_top_chk.sv
// Port-level checker of bus timing and page handshake for the event counter log unit
`timescale 1ns/1ps
module pec_top_chk
    import pec_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire pec_events_s events,
    input wire logic page_ready
);
    logic tk;
    logic rd_tk;
    logic cmd_tk;
    assign tk = hsel && hready && htrans == HTRANS_NONSEQ;
    assign rd_tk = tk && !hwrite;
    assign cmd_tk = tk && hwrite && haddr[7:0] == A_LOG_CMD && hsize == HSIZE_WORD;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_OKAY: assert property (hresp == HRESP_OKAY)
        else $error("response not OKAY");
    AST_WR_NOWAIT: assert property (tk && hwrite |=> hreadyout)
        else $error("write stalled");
    AST_RD_ONEWAIT: assert property (rd_tk |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WAIT_CAUSE: assert property (!hreadyout |-> $past(rd_tk))
        else $error("stall without read");
    AST_SNAP_ROSE: assert property ($rose(page_ready) |-> $past(cmd_tk, 2) && $past(hwdata[7:0]) == PAGE_PHY_EVT)
        else $error("page ready without page request");
    AST_SNAP_FELL: assert property ($fell(page_ready) |-> $past(tk) || $past(tk, 2))
        else $error("page ready dropped without access");
    AST_DATA_HOLD: assert property ($changed(hrdata) |-> $past(rd_tk) || $past(rd_tk, 2))
        else $error("read data changed without read");
    AST_BAD_PAGE: assert property (cmd_tk ##1 hwdata[7:0] != PAGE_PHY_EVT |=> !page_ready)
        else $error("unknown page made ready");
endmodule
bind pec_top pec_top_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .events, .page_ready);

// ### bench/test_phy_event_counter_log.sv
// Self-checking bench for the link event counter log unit
`timescale 1ns/1ps
module test_phy_event_counter_log
    import pec_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, page_ready;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = '0;
    logic lvl = 1'b0;
    pec_events_s ev, p;
    int n_errors = 0, n_compared = 0, seed = 32'h79b01395;
    int cnt[NCNT];
    byte unsigned pg[512];
    byte unsigned gp[512];
    pec_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .events(ev), .page_ready);
    pec_host_model u_host (.hclk, .ev);
    initial forever #20 hclk = ~hclk;
    task automatic end_sim;
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // ------------------------------------------------------------
    // Bus master: hready is judged at the falling edge, where it has settled
    // ------------------------------------------------------------
    task automatic wait_rdy;
        logic r;
        int k;
        k = 0;
        do begin
            @(negedge hclk);
            r = hreadyout;
            rd = hrdata;
            @(posedge hclk);
            k++;
        end while (r !== 1'b1 && k < 20);
        if (r !== 1'b1) begin
            n_errors++;
            end_sim();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
    endtask
    // ------------------------------------------------------------
    // Reference counters
    // ------------------------------------------------------------
    function automatic int mx(input int i);
        return (i == CI_RDY) ? 'hff : 'hffff;
    endfunction
    function automatic logic [31:0] rep(input int i);
        if (cnt[i] == mx(i)) return (i == CI_RDY) ? 32'hffff : 32'hffff_ffff;
        return 32'(cnt[i]);
    endfunction
    task automatic inc(input int i, input logic on);
        if (on && cnt[i] < mx(i)) cnt[i]++;
    endtask
    task automatic ev_pulse(input pec_events_s e);
        u_host.pulse(e);
        if (e.selftest) cnt = '{default: 0};
        inc(CI_ICRC, e.cmd_icrc);
        inc(CI_RXCRC, e.rx_crc_err);
        inc(CI_RXERR, e.rx_other_err);
    endtask
    task automatic link(input logic up);
        u_host.link(up);
        inc(CI_RDY, up && !lvl);
        lvl = up;
    endtask
    task automatic chk_regs;
        for (int i = 0; i < NCNT; i++) begin
            bus(1'b0, A_CNT_BASE + 8'(4 * i), '0);
            chk("counter", rd, rep(i));
        end
    endtask
    task automatic read_page(input logic clr);
        int o, s, n;
        logic [15:0] id;
        pg = '{default: 0};
        for (int i = 0; i < NCNT; i++) begin
            o = CNT_OFF[i];
            id = {1'b0, CNT_CODE[i], CNT_ID[i]};
            pg[o] = id[7:0];
            pg[o + 1] = id[15:8];
            for (int k = 0; k < 2 * CNT_CODE[i]; k++) pg[o + 2 + k] = 8'(rep(i) >> (8 * k));
        end
        s = 0;
        for (int b = 0; b < 511; b++) s += pg[b];
        pg[511] = 8'(-s);
        bus(1'b1, A_LOG_CMD, {23'h0, clr, PAGE_PHY_EVT});
        if (clr) cnt = '{default: 0};
        for (int j = 0; j < PAGE_WORDS; j++) begin
            bus(1'b0, A_LOG_DATA, '0);
            chk("page word", rd, {pg[4*j+3], pg[4*j+2], pg[4*j+1], pg[4*j]});
            for (int k = 0; k < 4; k++) gp[4 * j + k] = rd[8 * k +: 8];
        end
        // Host walk over what was read: entries run until a zero identifier
        o = 4;
        n = 0;
        while (o < 510 && {gp[o + 1], gp[o]} != 16'h0000) begin
            o += 2 + 2 * gp[o + 1][6:4];
            n++;
        end
        chk("entry count", n, NCNT);
        chk("ready after page", 32'(page_ready), 0);
    endtask
    task automatic traffic(input int n);
        for (int i = 0; i < n; i++) begin
            ev_pulse(pec_events_s'(8'($random(seed)) & 8'h43));
            link($random(seed) % 2 != 0);
        end
    endtask
    initial begin
        cnt = '{default: 0};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk_regs();
        bus(1'b0, A_UNMAPPED, '0);
        chk("unmapped", rd, 0);
        traffic(300);
        // Enough link edges to drive the narrow counter into saturation
        for (int i = 0; i < 600; i++) link(i[0] == 1'b0);
        u_host.sig(1'b1, 0);
        u_host.sig(1'b0, 3);
        u_host.sig(1'b1, 5);
        inc(CI_SIG, 1'b1);
        inc(CI_SIG, 1'b1);
        chk_regs();
        read_page(1'b0);
        traffic(40);
        read_page(1'b1);
        chk_regs();
        traffic(20);
        p = '0;
        p.selftest = 1'b1;
        p.cmd_icrc = 1'b1;
        ev_pulse(p);
        chk_regs();
        bus(1'b1, A_LOG_CMD, 32'h12);
        bus(1'b0, A_LOG_STAT, '0);
        chk("status", {30'h0, rd[1:0]}, 32'h2);
        bus(1'b0, A_LOG_DATA, '0);
        chk("data idle", rd, 0);
        traffic(10);
        link(1'b0);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        cnt = '{default: 0};
        chk_regs();
        end_sim();
    end
endmodule

// ### core/pec_page_img.sv
// Builds the 512-byte counter log page and returns one word of it
`timescale 1ns/1ps
module pec_page_img
    import pec_pkg::*;
(
    input wire pec_snap_t snap,
    input wire logic [WIDX_W-1:0] word_idx,
    output logic [31:0] word
);
    logic [IMG_BYTES-1:0][7:0] img;
    logic [7:0] sum;
    logic [7:0] cksum;
    logic [15:0] id;
    logic [8:0] bi;

    always_comb begin
        img = '0;
        sum = 8'h00;
        id = 16'h0000;
        for (int i = 0; i < NCNT; i++) begin
            // Vendor bit stays clear; every entry carries its size code
            id = {1'b0, CNT_CODE[i], CNT_ID[i]};
            img[int'(CNT_OFF[i])] = id[7:0];
            img[int'(CNT_OFF[i]) + 1] = id[15:8];
            for (int j = 0; j < 8; j++) begin
                if (j < 2 * int'(CNT_CODE[i])) begin
                    img[int'(CNT_OFF[i]) + 2 + j] = snap[i][8*j +: 8];
                end
            end
        end
        // Bytes past the last entry stay zero, forming the terminator
        for (int b = 0; b < IMG_BYTES; b++) begin
            sum = sum + img[b];
        end
        cksum = 8'h00 - sum;
    end

    always_comb begin
        word = 32'h0000_0000;
        bi = 9'h000;
        for (int k = 0; k < 4; k++) begin
            bi = {word_idx, 2'(k)};
            if (bi < 9'(IMG_BYTES)) begin
                word[8*k +: 8] = img[bi];
            end else if (bi == CKSUM_BYTE) begin
                word[8*k +: 8] = cksum;
            end
        end
    end
endmodule

// ### core/pec_sat_cnt.sv
// Saturating event counter with one-extended report value
`timescale 1ns/1ps
module pec_sat_cnt
    import pec_pkg::*;
#(
    parameter int PHYS_W = 16,
    parameter int REP_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic inc,
    input wire logic clr,
    output logic [CNT_VAL_W-1:0] rep_val
);
    localparam logic [CNT_VAL_W-1:0] REP_MASK =
        (REP_W >= CNT_VAL_W) ? '1 : ((64'h1 << REP_W) - 64'h1);

    logic [PHYS_W-1:0] cnt_r;
    logic [PHYS_W-1:0] cnt_nxt;
    logic sat;

    assign sat = &cnt_r;

    always_comb begin
        cnt_nxt = cnt_r;
        if (clr) begin
            // Event in the clearing cycle lands after the clear
            cnt_nxt = inc ? PHYS_W'(1) : '0;
        end else if (inc && !sat) begin
            cnt_nxt = cnt_r + PHYS_W'(1);
        end
    end

    always_comb begin
        rep_val = CNT_VAL_W'(cnt_r);
        if (sat) begin
            rep_val = REP_MASK;
        end
    end

    // Only power-on reset reaches the count; link and soft resets do not
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ### core/pec_top.sv
// Link event counter log unit with AHB-Lite register access
// Contract
// - Counters survive link and soft resets only
// - Self-test frame clears every counter
// - Read-and-clear snapshots first, then clears
// - Entry starts with 16-bit identifier
// - Identifier bits 14:12 give counter size
// - Vendor identifiers still honour size code
// - Unused slots carry identifier zero
// - Unimplemented optional counters never appear
// - Identifier zero terminates the list
// - Count commands ending with interface CRC error
// - Count link not-ready to ready entries
// - Count acknowledged reset signature frames
// - Count received frames rejected for CRC
// - Count received frames rejected otherwise
// - Mandatory counters present, retry counters absent
// - Page is 512 bytes, reserved header
// - Saturated narrow counter reports all ones
// - Counters saturate, never wrap
// - Value length is multiple of 16 bits
// - Last byte makes page sum zero
// - Reserved bytes read as zero
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module pec_top
    import pec_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire pec_events_s events,
    output logic page_ready
);
    pec_top_s s_r;
    pec_top_s s_nxt;
    pec_snap_t live;
    logic [NCNT-1:0] cnt_inc;
    logic cnt_clr;
    logic [31:0] img_word;
    logic [31:0] rdata;
    logic cmd_wr;

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NCNT; g++) begin : g_cnt
        pec_sat_cnt #(
            .PHYS_W(int'(CNT_PHYS[g])),
            .REP_W(16 * int'(CNT_CODE[g]))
        ) u_cnt (
            .hclk(hclk),
            .hresetn(hresetn),
            .inc(cnt_inc[g]),
            .clr(cnt_clr),
            .rep_val(live[g])
        );
    end

    pec_page_img u_img (
        .snap(s_r.snap),
        .word_idx(s_r.word_idx),
        .word(img_word)
    );

    // ------------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------------
    always_comb begin
        cnt_inc = '0;
        cnt_inc[CI_ICRC] = events.cmd_icrc;
        cnt_inc[CI_RDY] = events.link_ready & ~s_r.rdy_prev;
        cnt_inc[CI_SIG] = s_r.sig_pend & events.sig_rok;
        cnt_inc[CI_RXCRC] = events.rx_crc_err;
        cnt_inc[CI_RXERR] = events.rx_other_err;
    end

    assign cmd_wr = s_r.dph_act && s_r.dph_wr && (s_r.dph_addr == A_LOG_CMD);

    // Clear shares the cycle of the snapshot, so reported values predate it
    assign cnt_clr = events.selftest
        | (cmd_wr && hwdata[CMD_PAGE_LSB +: 8] == PAGE_PHY_EVT
           && hwdata[CMD_CLR_BIT]);

    // ------------------------------------------------------------------
    // Read data select
    // ------------------------------------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        case (s_r.dph_addr)
            A_LOG_STAT: begin
                rdata[STAT_READY_BIT] = s_r.page_ready;
                rdata[STAT_BAD_BIT] = s_r.bad_page;
                rdata[STAT_IDX_LSB +: WIDX_W] = s_r.word_idx;
            end
            A_LOG_DATA: begin
                if (s_r.page_ready) begin
                    rdata = img_word;
                end
            end
            default: begin
                for (int i = 0; i < NCNT; i++) begin
                    if (s_r.dph_addr == A_CNT_BASE + 8'(4 * i)) begin
                        rdata = live[i][31:0];
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdy_prev = events.link_ready;
        // A signature frame waits for the host's answer before it counts
        if (events.sig_sent) begin
            s_nxt.sig_pend = 1'b1;
        end else if (events.sig_rok || events.sig_rerr) begin
            s_nxt.sig_pend = 1'b0;
        end

        if (cmd_wr) begin
            if (hwdata[CMD_PAGE_LSB +: 8] == PAGE_PHY_EVT) begin
                s_nxt.snap = live;
                s_nxt.page_ready = 1'b1;
                s_nxt.bad_page = 1'b0;
                s_nxt.word_idx = '0;
            end else begin
                s_nxt.page_ready = 1'b0;
                s_nxt.bad_page = 1'b1;
            end
        end

        // Reads take one wait state so a write just before is visible
        if (s_r.dph_act && !s_r.dph_wr && !s_r.rd_ready) begin
            s_nxt.rd_ready = 1'b1;
            s_nxt.hrdata = rdata;
            if (s_r.dph_addr == A_LOG_DATA && s_r.page_ready) begin
                s_nxt.word_idx = s_r.word_idx + WIDX_W'(1);
                if (s_r.word_idx == WIDX_W'(PAGE_WORDS - 1)) begin
                    s_nxt.page_ready = 1'b0;
                end
            end
        end

        if (hready) begin
            s_nxt.dph_act = hsel && (htrans == HTRANS_NONSEQ);
            s_nxt.dph_wr = hwrite;
            s_nxt.dph_addr = (hsize == HSIZE_WORD) ? haddr[7:0] : A_UNMAPPED;
            s_nxt.rd_ready = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout = !(s_r.dph_act && !s_r.dph_wr && !s_r.rd_ready);
    assign hresp = HRESP_OKAY;
    assign hrdata = s_r.hrdata;
    assign page_ready = s_r.page_ready;
endmodule

// ### pkg/pec_pkg.sv
// Constants, carriers and state types for the link event counter log unit
package pec_pkg;

    // ------------------------------------------------------------------
    // Counter set and log page layout
    // ------------------------------------------------------------------
    localparam int NCNT = 5;
    localparam int CNT_VAL_W = 64;
    localparam int IMG_BYTES = 36;
    localparam int PAGE_WORDS = 128;
    localparam int WIDX_W = 7;
    localparam logic [8:0] CKSUM_BYTE = 9'h1ff;
    localparam logic [7:0] PAGE_PHY_EVT = 8'h11;
    localparam int ID_SIZE_LSB = 12;
    localparam int ID_VENDOR_BIT = 15;

    // Counter slots: index 0 is the first entry of the page
    localparam int CI_ICRC = 0;
    localparam int CI_RDY = 1;
    localparam int CI_SIG = 2;
    localparam int CI_RXCRC = 3;
    localparam int CI_RXERR = 4;
    localparam logic [NCNT-1:0][11:0] CNT_ID = {12'h00d, 12'h00b, 12'h00a, 12'h009, 12'h001};
    localparam logic [NCNT-1:0][2:0] CNT_CODE = {3'h2, 3'h2, 3'h2, 3'h1, 3'h2};
    localparam logic [NCNT-1:0][6:0] CNT_PHYS = {7'h10, 7'h10, 7'h10, 7'h08, 7'h10};
    localparam logic [NCNT-1:0][8:0] CNT_OFF = {9'h01a, 9'h014, 9'h00e, 9'h00a, 9'h004};

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] A_LOG_CMD = 8'h00;
    localparam logic [7:0] A_LOG_STAT = 8'h04;
    localparam logic [7:0] A_LOG_DATA = 8'h08;
    localparam logic [7:0] A_CNT_BASE = 8'h10;
    localparam logic [7:0] A_UNMAPPED = 8'hff;
    localparam int CMD_PAGE_LSB = 0;
    localparam int CMD_CLR_BIT = 8;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_BAD_BIT = 1;
    localparam int STAT_IDX_LSB = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic selftest;
        logic cmd_icrc;
        logic link_ready;
        logic sig_sent;
        logic sig_rok;
        logic sig_rerr;
        logic rx_crc_err;
        logic rx_other_err;
    } pec_events_s;

    typedef logic [NCNT-1:0][CNT_VAL_W-1:0] pec_snap_t;

    typedef struct packed {
        logic dph_act;
        logic dph_wr;
        logic [7:0] dph_addr;
        logic rd_ready;
        logic [31:0] hrdata;
        logic page_ready;
        logic bad_page;
        logic [WIDX_W-1:0] word_idx;
        logic rdy_prev;
        logic sig_pend;
        pec_snap_t snap;
    } pec_top_s;

endpackage
